// [asp_serial_port.sv]
// Operation
// - baud timer is 16 bits, prescaled by 1, 4, 12 or 48
// - timer counts up from reload and reloads on wrap to zero
// - bit rate is clock/(65536-reload)/2/prescale
// - no transmit or receive while the baud generator is off
// - frame: low start, data LSB first, extra bit, high stops
// - data length five to eight bits
// - parity odd, even, mark or space, made and checked
// - parity disables extra bit; two stops only for 6-8 bits
// - data write fills holding register, clears holding-empty
// - transmit-done set at start of stop bit time
// - extra bit without parity sends transmit extra-bit control
// - receiver accepts frames only with receive enable set
// - store byte only if FIFO not full and stops high
// - byte arriving at full FIFO is lost, overrun flag set
// - storing sets receive-done; multiprocessor needs extra bit one
// - data read returns oldest byte and frees its entry
// - clearing receive-done ignored while more bytes wait
// - done flags clear only by software write
// - received extra-bit status: extra bit or first stop bit
// - parity failure sets sticky parity error flag
//
// Design decision made here: the Wishbone interface to the registers.
module asp_serial_port (
    input  wire logic          sys_clk,      // 125 MHz clock
    input  wire logic          reset,        // sync reset
    input  asp_pkg::asp_wb_req_s wb_req,     // wishbone request
    output asp_pkg::asp_wb_rsp_s wb_rsp,     // wishbone answer
    input  wire logic          receive_pin,  // serial in
    output logic               transmit_pin, // serial out
    output logic               serial_event  // done flag level
);
    localparam asp_pkg::asp_state_s ST_RST = '{
        ctrl: asp_pkg::CTRL_RST, fmt: asp_pkg::FMT_RST,
        bgc: '0, rl: '0, ack: 1'b0, rdat: '0, hold: '0,
        hold_full: 1'b0, txst: asp_pkg::TX_IDLE, txsh: '0,
        txx: 1'b0, txhalf: 1'b0, txcnt: '0, txout: 1'b1,
        rxs1: 1'b1, rxs2: 1'b1, rxs3: 1'b1,
        rxst: asp_pkg::RX_IDLE, rxhalf: 1'b0, rxcnt: '0,
        rxsh: '0, rxx: 1'b0, rxstop1: 1'b0, rxbad: 1'b0,
        mem: '0, rd: '0, wr: '0, cnt: '0};
    localparam logic [1:0] FULL = 2'(asp_pkg::FIFO_DEPTH);
    localparam logic [1:0] PLAST = 2'(asp_pkg::FIFO_DEPTH - 1);
    localparam logic [7:0] IDX_CTRL_R = asp_pkg::IDX_CTRL;

    asp_pkg::asp_state_s    s;
    asp_pkg::asp_state_s    n;
    asp_pkg::asp_baud_cfg_s bcfg;
    asp_pkg::asp_ctrl_s     rd_ctrl;
    asp_pkg::asp_ctrl_s     wd;
    logic       tx_tick;
    logic       rx_tick;
    logic       rx_restart;
    logic       req;
    logic       acc;
    logic       wr;
    logic       rd;
    logic [7:0] idx;
    logic       xbe_e;
    logic [2:0] last;
    logic [2:0] halves;
    logic       go_stop;
    logic       ti_set;
    logic       done;
    logic       ok;
    logic       rx_xb;
    logic       push;
    logic       pop;
    logic [8:0] head;

    function automatic logic par_bit(logic [7:0] d, logic [1:0] pt,
                                     logic [2:0] lst);
        logic [7:0] m;
        logic       x;
        m = 8'hFF >> (3'h7 - lst);
        x = ^(d & m);
        unique case (pt)
            asp_pkg::PT_ODD:   par_bit = ~x;
            asp_pkg::PT_EVEN:  par_bit = x;
            asp_pkg::PT_MARK:  par_bit = 1'b1;
            asp_pkg::PT_SPACE: par_bit = 1'b0;
        endcase
    endfunction : par_bit

    function automatic logic [1:0] inc_ptr(logic [1:0] p);
        inc_ptr = (p == PLAST) ? 2'h0 : 2'(p + 2'h1);
    endfunction : inc_ptr

    // ==========================================
    // baud generators; receive copy realigns
    assign bcfg = '{run: s.bgc.run, ps: s.bgc.ps, reload: s.rl};

    asp_baud_gen u_tx_baud (
        .sys_clk (sys_clk),
        .reset   (reset),
        .cfg     (bcfg),
        .restart (1'b0),
        .tick    (tx_tick)
    );

    asp_baud_gen u_rx_baud (
        .sys_clk (sys_clk),
        .reset   (reset),
        .cfg     (bcfg),
        .restart (rx_restart),
        .tick    (rx_tick)
    );

    // ==========================================
    // next state
    always_comb
    begin
        n = s;
        xbe_e = s.fmt.xbe & ~s.fmt.pe;
        last = 3'(asp_pkg::LAST_5 + {1'b0, s.fmt.dlen});
        if (!s.fmt.sbl)
            halves = asp_pkg::HALF_1;
        else if (s.fmt.dlen == asp_pkg::DLEN_5)
            halves = asp_pkg::HALF_15;
        else
            halves = asp_pkg::HALF_2;
        head = s.mem[s.rd];
        go_stop = 1'b0;
        ti_set = 1'b0;
        done = 1'b0;
        ok = 1'b0;
        rx_xb = 1'b0;
        push = 1'b0;

        // transmit
        if (tx_tick && s.bgc.run)
        begin
            unique case (s.txst)
                asp_pkg::TX_IDLE:
                    if (s.hold_full)
                    begin
                        n.txst = asp_pkg::TX_START;
                        n.txsh = s.hold;
                        n.txx = s.fmt.pe ?
                            par_bit(s.hold, s.fmt.ptype, last) :
                            s.ctrl.tbx;
                        n.hold_full = 1'b0;
                        n.ctrl.thre = 1'b1;
                        n.txhalf = 1'b0;
                        n.txout = 1'b0;
                    end
                asp_pkg::TX_STOP:
                begin
                    n.txcnt = 3'(s.txcnt - 3'h1);
                    if (s.txcnt == 3'h1)
                        n.txst = asp_pkg::TX_IDLE;
                end
                asp_pkg::TX_START, asp_pkg::TX_DATA, asp_pkg::TX_XBIT:
                begin
                    n.txhalf = ~s.txhalf;
                    if (s.txhalf)
                    begin
                        if (s.txst == asp_pkg::TX_START)
                        begin
                            n.txst = asp_pkg::TX_DATA;
                            n.txcnt = 3'h0;
                            n.txout = s.txsh[0];
                        end
                        else if (s.txst == asp_pkg::TX_XBIT)
                            go_stop = 1'b1;
                        else if (s.txcnt != last)
                        begin
                            n.txcnt = 3'(s.txcnt + 3'h1);
                            n.txsh = s.txsh >> 1;
                            n.txout = s.txsh[1];
                        end
                        else if (s.fmt.pe | xbe_e)
                        begin
                            n.txst = asp_pkg::TX_XBIT;
                            n.txout = s.txx;
                        end
                        else
                            go_stop = 1'b1;
                    end
                end
                default:
                    n.txst = asp_pkg::TX_IDLE;
            endcase
        end
        if (go_stop)
        begin
            n.txst = asp_pkg::TX_STOP;
            n.txout = 1'b1;
            n.txcnt = halves;
            ti_set = 1'b1;
        end

        // receive
        n.rxs1 = receive_pin;
        n.rxs2 = s.rxs1;
        n.rxs3 = s.rxs2;
        rx_restart = s.rxst == asp_pkg::RX_IDLE && s.ctrl.ren &&
                     s.bgc.run && s.rxs3 && !s.rxs2;
        if (rx_restart)
        begin
            n.rxst = asp_pkg::RX_START;
            n.rxhalf = 1'b0;
            n.rxbad = 1'b0;
            n.rxsh = '0;
        end
        else if (rx_tick && s.bgc.run && s.rxst != asp_pkg::RX_IDLE)
        begin
            n.rxhalf = ~s.rxhalf;
            if (!s.rxhalf)
            begin
                unique case (s.rxst)
                    asp_pkg::RX_START:
                        if (s.rxs2)
                            n.rxst = asp_pkg::RX_IDLE;
                        else
                        begin
                            n.rxst = asp_pkg::RX_DATA;
                            n.rxcnt = 3'h0;
                        end
                    asp_pkg::RX_DATA:
                    begin
                        n.rxsh[s.rxcnt] = s.rxs2;
                        n.rxcnt = 3'(s.rxcnt + 3'h1);
                        if (s.rxcnt == last)
                        begin
                            n.rxcnt = 3'h0;
                            n.rxst = (s.fmt.pe | xbe_e) ?
                                asp_pkg::RX_XBIT : asp_pkg::RX_STOP;
                        end
                    end
                    asp_pkg::RX_XBIT:
                    begin
                        n.rxx = s.rxs2;
                        n.rxst = asp_pkg::RX_STOP;
                    end
                    asp_pkg::RX_STOP:
                    begin
                        if (s.rxcnt == 3'h0)
                            n.rxstop1 = s.rxs2;
                        if (!s.rxs2)
                            n.rxbad = 1'b1;
                        if (s.fmt.sbl && s.fmt.dlen != asp_pkg::DLEN_5
                            && s.rxcnt == 3'h0)
                            n.rxcnt = 3'h1;
                        else
                        begin
                            done = 1'b1;
                            n.rxst = asp_pkg::RX_IDLE;
                        end
                    end
                    default:
                        n.rxst = asp_pkg::RX_IDLE;
                endcase
            end
        end
        ok = done && !s.rxbad && s.rxs2;
        rx_xb = xbe_e ? s.rxx :
                (s.rxcnt == 3'h0 ? s.rxs2 : s.rxstop1);

        // bus slave
        req = wb_req.cyc & wb_req.stb;
        acc = req & s.ack;
        wr = acc & wb_req.we & wb_req.sel[0];
        rd = acc & ~wb_req.we;
        idx = wb_req.adr[9:2];
        wd = wb_req.dat[7:0];
        n.ack = req & ~s.ack;
        rd_ctrl = s.ctrl;
        rd_ctrl.rbx = head[8];
        n.rdat = 8'h00;
        if (req & ~s.ack)
        begin
            case (idx)
                IDX_CTRL_R: n.rdat = rd_ctrl;
                asp_pkg::IDX_DATA: n.rdat = head[7:0];
                asp_pkg::IDX_FMT:  n.rdat = s.fmt;
                asp_pkg::IDX_BGC:  n.rdat = s.bgc;
                asp_pkg::IDX_RLL:  n.rdat = s.rl[7:0];
                asp_pkg::IDX_RLH:  n.rdat = s.rl[15:8];
                default:           n.rdat = 8'h00;
            endcase
        end
        if (wr)
        begin
            case (idx)
                IDX_CTRL_R:
                begin
                    n.ctrl.ovr = wd.ovr;
                    n.ctrl.perr = wd.perr;
                    n.ctrl.ren = wd.ren;
                    n.ctrl.tbx = wd.tbx;
                    n.ctrl.ti = wd.ti;
                    if (wd.ri || s.cnt <= 2'h1)
                        n.ctrl.ri = wd.ri;
                end
                asp_pkg::IDX_DATA:
                begin
                    n.hold = wb_req.dat[7:0];
                    n.hold_full = 1'b1;
                    n.ctrl.thre = 1'b0;
                end
                asp_pkg::IDX_FMT: n.fmt = wb_req.dat[7:0];
                asp_pkg::IDX_BGC:
                    n.bgc = wb_req.dat[7:0] & asp_pkg::BGC_MASK;
                asp_pkg::IDX_RLL: n.rl[7:0] = wb_req.dat[7:0];
                asp_pkg::IDX_RLH: n.rl[15:8] = wb_req.dat[7:0];
                default: ;
            endcase
        end

        // fifo and event flags, set wins
        pop = rd && idx == asp_pkg::IDX_DATA && s.cnt != 2'h0;
        if (pop)
            n.rd = inc_ptr(s.rd);
        if (ok && s.cnt == FULL)
            n.ctrl.ovr = 1'b1;
        else if (ok)
        begin
            push = 1'b1;
            n.mem[s.wr] = {rx_xb, s.rxsh};
            n.wr = inc_ptr(s.wr);
            if (!s.fmt.mce || rx_xb)
                n.ctrl.ri = 1'b1;
            if (s.fmt.pe &&
                s.rxx != par_bit(s.rxsh, s.fmt.ptype, last))
                n.ctrl.perr = 1'b1;
        end
        n.cnt = 2'(s.cnt + {1'b0, push} - {1'b0, pop});
        if (ti_set)
            n.ctrl.ti = 1'b1;
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
            s <= ST_RST;
        else
            s <= n;
    end

    assign transmit_pin = s.txout;
    assign serial_event = s.ctrl.ti | s.ctrl.ri;
    assign wb_rsp = '{ack: s.ack, dat: {24'h000000, s.rdat}};

    // ==========================================
    // checks
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);

    a_idle_line_high: assert property (
        s.txst == asp_pkg::TX_IDLE |-> transmit_pin)
        else $error("line not high while idle");
    a_start_bit_low: assert property (
        s.txst == asp_pkg::TX_START |-> !transmit_pin)
        else $error("start bit not low");
    a_no_start_off: assert property (
        s.txst == asp_pkg::TX_IDLE && !s.bgc.run
        |=> s.txst == asp_pkg::TX_IDLE)
        else $error("frame started with generator off");
    a_write_clears_empty: assert property (
        wr && idx == asp_pkg::IDX_DATA |=> !s.ctrl.thre && s.hold_full)
        else $error("data write did not fill holding");
    a_done_at_stop: assert property (
        s.txst == asp_pkg::TX_STOP && $past(s.txst) != asp_pkg::TX_STOP
        |-> s.ctrl.ti && transmit_pin)
        else $error("transmit done not set at stop");
    a_fifo_overrun: assert property (
        ok && s.cnt == FULL |=> s.ctrl.ovr && s.cnt == 2'(FULL - $past(pop)))
        else $error("overrun not flagged");
    a_fifo_bound: assert property (
        s.cnt <= FULL)
        else $error("fifo count beyond depth");
    a_ri_held: assert property (
        wr && idx == IDX_CTRL_R && !wd.ri && s.ctrl.ri && s.cnt > 2'h1
        |=> s.ctrl.ri)
        else $error("receive done cleared with bytes waiting");
    a_rx_gated: assert property (
        s.rxst == asp_pkg::RX_IDLE && !s.ctrl.ren
        |=> s.rxst == asp_pkg::RX_IDLE)
        else $error("frame taken with receiver disabled");

endmodule : asp_serial_port

// [asp_pkg.sv]
package asp_pkg;

    // ==========================================
    // register map (index; byte addr = 4*index)
    localparam int         FIFO_DEPTH = 3;
    localparam logic [7:0] IDX_CTRL   = 8'h98;
    localparam logic [7:0] IDX_DATA   = 8'h99;
    localparam logic [7:0] IDX_FMT    = 8'hA9;
    localparam logic [7:0] IDX_BGC    = 8'hAB;
    localparam logic [7:0] IDX_RLL    = 8'hAC;
    localparam logic [7:0] IDX_RLH    = 8'hAD;
    localparam logic [7:0] BGC_MASK   = 8'h43;

    // ==========================================
    // fields and codes
    localparam logic [1:0]  PS_12    = 2'h0;
    localparam logic [1:0]  PS_4     = 2'h1;
    localparam logic [1:0]  PS_48    = 2'h2;
    localparam logic [1:0]  PS_1     = 2'h3;
    localparam logic [5:0]  DIV_12   = 6'h0C;
    localparam logic [5:0]  DIV_4    = 6'h04;
    localparam logic [5:0]  DIV_48   = 6'h30;
    localparam logic [5:0]  DIV_1    = 6'h01;
    localparam logic [15:0] TMR_TOP  = 16'hFFFF;
    localparam logic [1:0]  PT_ODD   = 2'h0;
    localparam logic [1:0]  PT_EVEN  = 2'h1;
    localparam logic [1:0]  PT_MARK  = 2'h2;
    localparam logic [1:0]  PT_SPACE = 2'h3;
    localparam logic [1:0]  DLEN_5   = 2'h0;
    localparam logic [2:0]  LAST_5   = 3'h4;
    localparam logic [2:0]  HALF_1   = 3'h2;
    localparam logic [2:0]  HALF_15  = 3'h3;
    localparam logic [2:0]  HALF_2   = 3'h4;

    typedef struct packed {
        logic ovr; logic perr; logic thre; logic ren;
        logic tbx; logic rbx;  logic ti;   logic ri;
    } asp_ctrl_s;
    typedef struct packed {
        logic mce; logic [1:0] ptype; logic pe;
        logic [1:0] dlen; logic xbe; logic sbl;
    } asp_fmt_s;
    typedef struct packed {
        logic rsv7; logic run; logic [3:0] rsv; logic [1:0] ps;
    } asp_bgc_s;

    localparam asp_ctrl_s CTRL_RST = 8'h20;
    localparam asp_fmt_s  FMT_RST  = 8'h0C;

    typedef enum logic [4:0] {
        TX_IDLE = 5'h01, TX_START = 5'h02, TX_DATA = 5'h04,
        TX_XBIT = 5'h08, TX_STOP = 5'h10
    } asp_tx_e;
    typedef enum logic [4:0] {
        RX_IDLE = 5'h01, RX_START = 5'h02, RX_DATA = 5'h04,
        RX_XBIT = 5'h08, RX_STOP = 5'h10
    } asp_rx_e;

    // ==========================================
    // carriers and state
    typedef struct packed {
        logic cyc; logic stb; logic we; logic [3:0] sel;
        logic [9:0] adr; logic [31:0] dat;
    } asp_wb_req_s;
    typedef struct packed {
        logic ack; logic [31:0] dat;
    } asp_wb_rsp_s;
    typedef struct packed {
        logic run; logic [1:0] ps; logic [15:0] reload;
    } asp_baud_cfg_s;
    typedef struct packed {
        logic [5:0] pcnt; logic [15:0] tmr; logic tick;
    } asp_baud_st_s;
    typedef struct packed {
        asp_ctrl_s ctrl; asp_fmt_s fmt; asp_bgc_s bgc;
        logic [15:0] rl; logic ack; logic [7:0] rdat;
        logic [7:0] hold; logic hold_full;
        asp_tx_e txst; logic [7:0] txsh; logic txx;
        logic txhalf; logic [2:0] txcnt; logic txout;
        logic rxs1; logic rxs2; logic rxs3;
        asp_rx_e rxst; logic rxhalf; logic [2:0] rxcnt;
        logic [7:0] rxsh; logic rxx; logic rxstop1; logic rxbad;
        logic [FIFO_DEPTH-1:0][8:0] mem;
        logic [1:0] rd; logic [1:0] wr; logic [1:0] cnt;
    } asp_state_s;

endpackage : asp_pkg

// [asp_baud_gen.sv]
module asp_baud_gen (
    input  wire logic           sys_clk, // system clock
    input  wire logic           reset,   // sync reset
    input  asp_pkg::asp_baud_cfg_s cfg,  // run, prescale, reload
    input  wire logic           restart, // realign timer
    output logic                tick     // half-bit pulse
);
    asp_pkg::asp_baud_st_s st_r;
    asp_pkg::asp_baud_st_s st_nxt;
    logic [5:0]            pdiv;
    logic                  pre_tick;

    // ==========================================
    // prescaler and reload timer
    always_comb
    begin
        unique case (cfg.ps)
            asp_pkg::PS_12: pdiv = asp_pkg::DIV_12;
            asp_pkg::PS_4:  pdiv = asp_pkg::DIV_4;
            asp_pkg::PS_48: pdiv = asp_pkg::DIV_48;
            asp_pkg::PS_1:  pdiv = asp_pkg::DIV_1;
        endcase
        pre_tick = st_r.pcnt == 6'(pdiv - 6'h01);
        st_nxt = st_r;
        st_nxt.tick = 1'b0;
        if (!cfg.run || restart)
        begin
            st_nxt.pcnt = '0;
            st_nxt.tmr = cfg.reload;
        end
        else if (pre_tick)
        begin
            st_nxt.pcnt = '0;
            if (st_r.tmr == asp_pkg::TMR_TOP)
            begin
                st_nxt.tmr = cfg.reload;
                st_nxt.tick = 1'b1;
            end
            else
                st_nxt.tmr = 16'(st_r.tmr + 16'h0001);
        end
        else
            st_nxt.pcnt = 6'(st_r.pcnt + 6'h01);
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    assign tick = st_r.tick;

    // ==========================================
    // checks
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);

    a_timer_reload: assert property (
        cfg.run && !restart && pre_tick && st_r.tmr == asp_pkg::TMR_TOP
        |=> st_r.tmr == $past(cfg.reload) && tick)
        else $error("timer did not reload on wrap");
    a_timer_count: assert property (
        cfg.run && !restart && pre_tick && st_r.tmr != asp_pkg::TMR_TOP
        |=> st_r.tmr == 16'($past(st_r.tmr) + 16'h0001) && !tick)
        else $error("timer did not step by one");
    a_prescale_four: assert property (
        (cfg.run && !restart && cfg.ps == asp_pkg::PS_4 && st_r.pcnt == 0)
        ##1 (cfg.run && !restart && cfg.ps == asp_pkg::PS_4)[*3]
        |-> pre_tick)
        else $error("divide by four prescale wrong");
    a_idle_no_tick: assert property (
        !cfg.run ##1 !cfg.run |-> !tick)
        else $error("tick while generator stopped");

endmodule : asp_baud_gen

// [asp_peer.sv]
// ==========================================
// far serial node, sixteen clocks per bit
module asp_peer (
    input  wire logic sys_clk,  // bench clock
    input  wire logic line_in,  // from transmit_pin
    output logic      line_out  // to receive_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int BIT = 16;
    initial line_out = 1'h1;

    // f: start, data, extra, stop, sent lsb first
    task send(input logic [10:0] f);
        @(posedge sys_clk);
        for (int k = 0; k < 11; k++)
        begin
            line_out <= f[k];
            repeat (BIT) @(posedge sys_clk);
        end
        line_out <= 1'h1;
    endtask : send

    // s: the bit after the eight data bits
    task get(output logic [7:0] d, output logic s);
        @(negedge line_in);
        repeat (BIT / 2) @(negedge sys_clk);
        for (int k = 0; k < 8; k++)
        begin
            repeat (BIT) @(negedge sys_clk);
            d[k] = line_in;
        end
        repeat (BIT) @(negedge sys_clk);
        s = line_in;
    endtask : get
endmodule : asp_peer

// [test_async_serial_port_fifo.sv]
module test_async_serial_port_fifo;
    timeunit 1ns;
    timeprecision 1ps;
    logic                 sys_clk = 1'h0;
    logic                 reset = 1'h1;
    asp_pkg::asp_wb_req_s req;
    asp_pkg::asp_wb_rsp_s rsp;
    logic                 rx;
    logic                 tx;
    logic                 ev;
    int                   bad_count = 0;
    int                   num_checks = 0;

    always #4 sys_clk = ~sys_clk;

    asp_serial_port asp_serial_port_i (
        .sys_clk(sys_clk), .reset(reset), .wb_req(req), .wb_rsp(rsp),
        .receive_pin(rx), .transmit_pin(tx), .serial_event(ev));
    asp_peer asp_peer_i (.sys_clk(sys_clk), .line_in(tx), .line_out(rx));

    // ==========================================
    // reporting and bus
    task finish_test;
        $display("mismatches %0d checks %0d", bad_count, num_checks);
        if (bad_count == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : finish_test

    task chk(input logic [7:0] g, input logic [7:0] e);
        num_checks++;
        if (g !== e)
        begin
            bad_count++;
            $display("[FAIL] %0t got %h expected %h", $time, g, e);
        end
    endtask : chk

    task bus(input logic w, input logic [7:0] i, input logic [7:0] d,
             output logic [7:0] q);
        @(posedge sys_clk);
        req <= '{1'h1, 1'h1, w, 4'h1, {i, 2'h0}, {24'h000000, d}};
        do @(posedge sys_clk); while (rsp.ack !== 1'h1);
        q = rsp.dat[7:0];
        req <= '0;
    endtask : bus

    task wr(input logic [7:0] i, input logic [7:0] d);
        logic [7:0] q;
        bus(1'h1, i, d, q);
    endtask : wr

    task rdc(input logic [7:0] i, input logic [7:0] e);
        logic [7:0] q;
        bus(1'h0, i, 8'h00, q);
        chk(q, e);
    endtask : rdc

    // ==========================================
    // scenarios
    task t_regs;
        rdc(asp_pkg::IDX_CTRL, 8'h20);
        rdc(asp_pkg::IDX_FMT, 8'h0C);
        rdc(8'h10, 8'h00);
        wr(asp_pkg::IDX_BGC, 8'h41);
        rdc(asp_pkg::IDX_BGC, 8'h41);
        repeat (8) @(posedge sys_clk);
        wr(asp_pkg::IDX_BGC, 8'hBF);
        rdc(asp_pkg::IDX_BGC, 8'h03);
    endtask : t_regs

    task t_tx;
        logic [7:0] d;
        logic       s;
        wr(asp_pkg::IDX_DATA, 8'hA5);
        rdc(asp_pkg::IDX_CTRL, 8'h00);
        repeat (20) @(posedge sys_clk);
        chk({7'h00, tx}, 8'h01);
        wr(asp_pkg::IDX_RLL, 8'hF8);
        wr(asp_pkg::IDX_RLH, 8'hFF);
        fork
            asp_peer_i.get(d, s);
            wr(asp_pkg::IDX_BGC, 8'h43);
        join
        chk(d, 8'hA5);
        chk({7'h00, s}, 8'h01);
        rdc(asp_pkg::IDX_CTRL, 8'h22);
    endtask : t_tx

    task t_rx;
        logic [7:0] b [4];
        b = '{8'h11, 8'h22, 8'h33, 8'h44};
        asp_peer_i.send({2'h3, 8'h5A, 1'h0});
        wr(asp_pkg::IDX_CTRL, 8'h10);
        for (int k = 0; k < 4; k++)
            asp_peer_i.send({2'h3, b[k], 1'h0});
        repeat (10) @(posedge sys_clk);
        chk({7'h00, ev}, 8'h01);
        rdc(asp_pkg::IDX_CTRL, 8'hB5);
        wr(asp_pkg::IDX_CTRL, 8'h10);
        rdc(asp_pkg::IDX_CTRL, 8'h35);
        for (int k = 0; k < 3; k++)
            rdc(asp_pkg::IDX_DATA, b[k]);
        wr(asp_pkg::IDX_CTRL, 8'h10);
        repeat (2) @(posedge sys_clk);
        chk({7'h00, ev}, 8'h00);
    endtask : t_rx

    task t_par;
        wr(asp_pkg::IDX_FMT, 8'h3C);
        asp_peer_i.send({1'h1, 1'h0, 8'h01, 1'h0});
        repeat (10) @(posedge sys_clk);
        rdc(asp_pkg::IDX_CTRL, 8'h75);
        rdc(asp_pkg::IDX_DATA, 8'h01);
        wr(asp_pkg::IDX_CTRL, 8'h10);
        wr(asp_pkg::IDX_FMT, 8'h75);
        asp_peer_i.send({3'h7, 1'h0, 6'h2D, 1'h0});
        repeat (10) @(posedge sys_clk);
        rdc(asp_pkg::IDX_CTRL, 8'h35);
        rdc(asp_pkg::IDX_DATA, 8'h2D);
    endtask : t_par

    task t_mpc;
        logic [7:0] d;
        logic       s;
        wr(asp_pkg::IDX_CTRL, 8'h10);
        wr(asp_pkg::IDX_FMT, 8'h8E);
        asp_peer_i.send({1'h1, 1'h1, 8'h3C, 1'h0});
        repeat (10) @(posedge sys_clk);
        rdc(asp_pkg::IDX_CTRL, 8'h35);
        wr(asp_pkg::IDX_CTRL, 8'h10);
        asp_peer_i.send({1'h1, 1'h0, 8'h7E, 1'h0});
        repeat (10) @(posedge sys_clk);
        rdc(asp_pkg::IDX_CTRL, 8'h34);
        rdc(asp_pkg::IDX_DATA, 8'h3C);
        rdc(asp_pkg::IDX_CTRL, 8'h30);
        rdc(asp_pkg::IDX_DATA, 8'h7E);
        fork
            asp_peer_i.get(d, s);
            wr(asp_pkg::IDX_DATA, 8'hC3);
        join
        chk(d, 8'hC3);
        chk({7'h00, s}, 8'h00);
    endtask : t_mpc

    initial
    begin
        req = '0;
        repeat (12) @(posedge sys_clk);
        reset <= 1'h0;
        t_regs;
        t_tx;
        t_rx;
        t_par;
        t_mpc;
        finish_test;
    end

    initial
    begin
        repeat (20000) @(posedge sys_clk);
        bad_count++;
        finish_test;
    end
endmodule : test_async_serial_port_fifo
